// ==== hw/mcs_sequencer.sv ====
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "mcs_cfg.svh"
// What this block does
// - Bits 9:7 give bridge count 1..128
// - Clearing second temperature enable drops T2 slots
// - Start routine: bridge and bridge auto-zero
// - Start routine measures T1 when enabled
// - Fixed slot order, n bridges before each regular slot
// - Auto-zero slots short the front-end input
// - Mux picks configured temperature or bridge source
// - Six-bit shift drives signed step code
// - Shift code limited to plus/minus 31
// - Fine offset left to correction controller
// - Order selects its own resolution set
module mcs_sequencer
	import mcs_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Converter handshake
	input wire logic conv_done_i,
	input wire logic [15:0] conv_data_i,
	output logic conv_start_o,
	output logic conv_order_o,
	output logic [3:0] conv_res_o,
	// Analog front end
	output mcs_src_type mux_sel_o,
	output logic input_short_o,
	output logic [5:0] zero_shift_code_o,
	// Correction controller
	output logic [15:0] corr_data_o,
	output mcs_slot_type corr_slot_o,
	output logic corr_valid_o
);
	typedef enum logic [1:0] {
		MCS_ST_ISSUE,
		MCS_ST_WAIT
	} mcs_state_type;

	logic [31:0] cycle_config_word_ff;
	logic [5:0] coarse_zero_shift_ff;
	mcs_state_type state_ff;
	mcs_slot_type slot_ff;
	mcs_slot_type nxt_slot;
	logic in_bridge_ff;
	logic [7:0] br_cnt_ff;
	logic [7:0] n_minus1;
	logic [7:0] grp_last_ff;
	logic second_temp_enable;
	logic main_temp_enable;
	logic [15:0] last_data_ff;
	logic rd_ack_ff;
	logic res_bad;
	logic [5:0] wr_shift;

	assign second_temp_enable = cycle_config_word_ff[`MCS_T2E_BIT];
	assign main_temp_enable = cycle_config_word_ff[`MCS_T1E_BIT];
	assign n_minus1 = 8'((9'h001 << cycle_config_word_ff[`MCS_CNT_HI:`MCS_CNT_LO]) - 9'h001);
	assign wr_shift = avs_writedata_i[5:0];

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	// Writes complete at once; reads take one wait cycle for registered data
	assign avs_waitrequest_o = avs_read_i && !rd_ack_ff;

	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
			rd_ack_ff <= 1'b0;
		else
			rd_ack_ff <= avs_read_i && !rd_ack_ff;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (avs_read_i && !rd_ack_ff)
		begin
			unique case (avs_address_i)
				`MCS_ADDR_CYCLE: avs_readdata_o <= cycle_config_word_ff;
				`MCS_ADDR_SHIFT: avs_readdata_o <= {26'h0, coarse_zero_shift_ff};
				`MCS_ADDR_STATUS: avs_readdata_o <= {23'h0, res_bad, in_bridge_ff,
					3'(mux_sel_o), 4'(slot_ff)};
				`MCS_ADDR_RESULT: avs_readdata_o <= {16'h0, last_data_ff};
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
			cycle_config_word_ff <= `MCS_CYCLE_RST;
		else if (avs_write_i && avs_address_i == `MCS_ADDR_CYCLE)
			cycle_config_word_ff <= {11'h0, avs_writedata_i[20:0]};
	end

	// Code 100000 (minus 32) is outside the range and is refused
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
			coarse_zero_shift_ff <= `MCS_SHIFT_RST;
		else if (avs_write_i && avs_address_i == `MCS_ADDR_SHIFT && wr_shift != 6'h20)
			coarse_zero_shift_ff <= wr_shift;
	end

	assign zero_shift_code_o = coarse_zero_shift_ff;

	// ----------------------------------------------------------------
	// Converter settings
	// ----------------------------------------------------------------
	mcs_conv_gate mcs_conv_gate_i (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.order_i(cycle_config_word_ff[`MCS_ORDER_BIT]),
		.res_i(cycle_config_word_ff[`MCS_RES_HI:`MCS_RES_LO]),
		.order_o(conv_order_o),
		.res_o(conv_res_o),
		.res_bad_o(res_bad)
	);

	// ----------------------------------------------------------------
	// Slot sequencing
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (slot_ff)
			MCS_SL_ST_BR: nxt_slot = MCS_SL_ST_AZ;
			MCS_SL_ST_AZ: nxt_slot = main_temp_enable ? MCS_SL_ST_T1 : MCS_SL_T1AZ;
			MCS_SL_ST_T1: nxt_slot = MCS_SL_ST_T1AZ;
			MCS_SL_ST_T1AZ: nxt_slot = MCS_SL_T1AZ;
			MCS_SL_T1AZ: nxt_slot = MCS_SL_T1;
			MCS_SL_T1: nxt_slot = MCS_SL_BRAZ;
			MCS_SL_BRAZ: nxt_slot = second_temp_enable ? MCS_SL_T2AZ : MCS_SL_CMV;
			MCS_SL_T2AZ: nxt_slot = MCS_SL_T2;
			MCS_SL_T2: nxt_slot = MCS_SL_CMV;
			MCS_SL_CMV: nxt_slot = MCS_SL_T1AZ;
			default: nxt_slot = MCS_SL_ST_BR;
		endcase
	end

	// Regular slots are preceded by n bridge conversions; start slots are not
	// Group length is latched at its start so a smaller n written mid-group cannot strand the count
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			state_ff <= MCS_ST_ISSUE;
			slot_ff <= MCS_SL_ST_BR;
			in_bridge_ff <= 1'b0;
			br_cnt_ff <= 8'h00;
			grp_last_ff <= 8'h00;
		end
		else
		begin
			unique case (state_ff)
				MCS_ST_ISSUE: state_ff <= MCS_ST_WAIT;
				MCS_ST_WAIT:
				begin
					if (conv_done_i)
					begin
						state_ff <= MCS_ST_ISSUE;
						if (in_bridge_ff)
						begin
							if (br_cnt_ff == grp_last_ff)
							begin
								in_bridge_ff <= 1'b0;
								br_cnt_ff <= 8'h00;
							end
							else
								br_cnt_ff <= br_cnt_ff + 8'h01;
						end
						else
						begin
							slot_ff <= nxt_slot;
							in_bridge_ff <= (nxt_slot >= MCS_SL_T1AZ);
							grp_last_ff <= n_minus1;
						end
					end
				end
			endcase
		end
	end

	assign conv_start_o = (state_ff == MCS_ST_ISSUE);

	// ----------------------------------------------------------------
	// Multiplexer select
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			mux_sel_o <= MCS_SRC_BRIDGE;
			input_short_o <= 1'b0;
		end
		else if (in_bridge_ff)
		begin
			mux_sel_o <= MCS_SRC_BRIDGE;
			input_short_o <= 1'b0;
		end
		else
		begin
			unique case (slot_ff)
				MCS_SL_ST_AZ, MCS_SL_ST_T1AZ, MCS_SL_T1AZ, MCS_SL_BRAZ, MCS_SL_T2AZ:
				begin
					mux_sel_o <= MCS_SRC_ZERO;
					input_short_o <= 1'b1;
				end
				MCS_SL_ST_T1, MCS_SL_T1:
				begin
					mux_sel_o <= mcs_src_type'(3'h2 +
						3'(cycle_config_word_ff[`MCS_T1SRC_HI:`MCS_T1SRC_LO] % 3));
					input_short_o <= 1'b0;
				end
				MCS_SL_T2:
				begin
					mux_sel_o <= mcs_src_type'(3'h2 +
						3'(cycle_config_word_ff[`MCS_T2SRC_HI:`MCS_T2SRC_LO] % 3));
					input_short_o <= 1'b0;
				end
				MCS_SL_CMV:
				begin
					mux_sel_o <= MCS_SRC_CMV;
					input_short_o <= 1'b0;
				end
				default:
				begin
					mux_sel_o <= MCS_SRC_BRIDGE;
					input_short_o <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Results to the correction controller
	// ----------------------------------------------------------------
	// Raw values pass on untouched; fine offset removal happens downstream
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			corr_data_o <= 16'h0000;
			corr_slot_o <= MCS_SL_ST_BR;
			corr_valid_o <= 1'b0;
			last_data_ff <= 16'h0000;
		end
		else
		begin
			corr_valid_o <= (state_ff == MCS_ST_WAIT) && conv_done_i;
			if ((state_ff == MCS_ST_WAIT) && conv_done_i)
			begin
				corr_data_o <= conv_data_i;
				corr_slot_o <= in_bridge_ff ? MCS_SL_ST_BR : slot_ff;
				last_data_ff <= conv_data_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_short_on_az;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_ff == MCS_ST_WAIT && !in_bridge_ff && slot_ff == MCS_SL_BRAZ)
			|-> ##1 input_short_o;
	endproperty
	a_short_on_az: assert property (p_short_on_az) else $error("no short on auto-zero");

	property p_t2_skip;
		@(posedge mclk_i) disable iff (!resetn_i)
		(!$past(second_temp_enable) && $past(slot_ff) == MCS_SL_BRAZ && $changed(slot_ff))
			|-> slot_ff == MCS_SL_CMV;
	endproperty
	a_t2_skip: assert property (p_t2_skip) else $error("T2 slot while disabled");

	property p_wrap;
		@(posedge mclk_i) disable iff (!resetn_i)
		($past(slot_ff) == MCS_SL_CMV && slot_ff != MCS_SL_CMV) |-> slot_ff == MCS_SL_T1AZ;
	endproperty
	a_wrap: assert property (p_wrap) else $error("cycle did not wrap");

	property p_count;
		@(posedge mclk_i) disable iff (!resetn_i)
		in_bridge_ff |-> br_cnt_ff <= grp_last_ff;
	endproperty
	a_count: assert property (p_count) else $error("bridge count overrun");

	property p_shift_range;
		@(posedge mclk_i) disable iff (!resetn_i)
		zero_shift_code_o != 6'h20;
	endproperty
	a_shift_range: assert property (p_shift_range) else $error("shift out of range");

	property p_shift_write;
		@(posedge mclk_i) disable iff (!resetn_i)
		(avs_write_i && avs_address_i == `MCS_ADDR_SHIFT && avs_writedata_i[5:0] != 6'h20)
			|=> zero_shift_code_o == $past(avs_writedata_i[5:0]);
	endproperty
	a_shift_write: assert property (p_shift_write) else $error("shift not stored");

	property p_start_order;
		@(posedge mclk_i) disable iff (!resetn_i)
		($past(slot_ff) == MCS_SL_ST_BR && slot_ff != MCS_SL_ST_BR) |-> slot_ff == MCS_SL_ST_AZ;
	endproperty
	a_start_order: assert property (p_start_order) else $error("start order wrong");

	property p_t1_start;
		@(posedge mclk_i) disable iff (!resetn_i)
		($changed(slot_ff) && slot_ff == MCS_SL_ST_T1) |-> $past(main_temp_enable);
	endproperty
	a_t1_start: assert property (p_t1_start) else $error("T1 start while disabled");

	property p_result;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_ff == MCS_ST_WAIT && conv_done_i) |=> corr_valid_o && corr_data_o == $past(conv_data_i);
	endproperty
	a_result: assert property (p_result) else $error("result not forwarded");

	c_cmv: cover property (@(posedge mclk_i) slot_ff == MCS_SL_CMV);
	c_t2: cover property (@(posedge mclk_i) slot_ff == MCS_SL_T2);
	c_wrap: cover property (@(posedge mclk_i) $past(slot_ff) == MCS_SL_CMV && slot_ff == MCS_SL_T1AZ);
	c_no_t1: cover property (@(posedge mclk_i) $past(slot_ff) == MCS_SL_ST_AZ && slot_ff == MCS_SL_T1AZ);
endmodule : mcs_sequencer

// ==== hw/mcs_cfg.svh ====
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH
// Register byte offsets
`define MCS_ADDR_CYCLE 4'h0
`define MCS_ADDR_SHIFT 4'h4
`define MCS_ADDR_STATUS 4'h8
`define MCS_ADDR_RESULT 4'hC
// Cycle configuration word fields
`define MCS_CNT_HI 9
`define MCS_CNT_LO 7
`define MCS_T2E_BIT 10
`define MCS_T1E_BIT 11
`define MCS_ORDER_BIT 12
`define MCS_RES_HI 16
`define MCS_RES_LO 13
`define MCS_T1SRC_HI 18
`define MCS_T1SRC_LO 17
`define MCS_T2SRC_HI 20
`define MCS_T2SRC_LO 19
`define MCS_CYCLE_RST 32'h0000_3C00
`define MCS_SHIFT_RST 6'h00
// Shift code limits
`define MCS_SHIFT_MAX 6'h1F
`define MCS_SHIFT_MIN 6'h21
// Resolution limits per converter order
`define MCS_RES1_MIN 4'h9
`define MCS_RES1_MAX 4'hE
`define MCS_RES2_MIN 4'hB
`define MCS_RES2_MAX 4'hF
`endif

// ==== hw/mcs_pkg.sv ====
package mcs_pkg;
	typedef enum logic [2:0] {
		MCS_SRC_BRIDGE,
		MCS_SRC_ZERO,
		MCS_SRC_DIODE,
		MCS_SRC_BRRES,
		MCS_SRC_THERM,
		MCS_SRC_CMV
	} mcs_src_type;
	typedef enum logic [3:0] {
		MCS_SL_ST_BR,
		MCS_SL_ST_AZ,
		MCS_SL_ST_T1,
		MCS_SL_ST_T1AZ,
		MCS_SL_T1AZ,
		MCS_SL_T1,
		MCS_SL_BRAZ,
		MCS_SL_T2AZ,
		MCS_SL_T2,
		MCS_SL_CMV
	} mcs_slot_type;
endpackage : mcs_pkg

// ==== hw/mcs_conv_gate.sv ====
`timescale 1ns/100ps
`include "mcs_cfg.svh"
// Checks resolution against the converter order and holds the accepted settings
module mcs_conv_gate
	import mcs_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Requested settings
	input wire logic order_i,
	input wire logic [3:0] res_i,
	// Accepted settings
	output logic order_o,
	output logic [3:0] res_o,
	output logic res_bad_o
);
	logic ok;

	always_comb
	begin
		if (order_i)
			ok = (res_i >= `MCS_RES2_MIN) && (res_i <= `MCS_RES2_MAX);
		else
			ok = (res_i >= `MCS_RES1_MIN) && (res_i <= `MCS_RES1_MAX);
	end

	// Illegal pairs keep the last good setting so the converter never sees one
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			order_o <= 1'b0;
			res_o <= `MCS_RES1_MIN;
			res_bad_o <= 1'b0;
		end
		else
		begin
			res_bad_o <= !ok;
			if (ok)
			begin
				order_o <= order_i;
				res_o <= res_i;
			end
		end
	end
endmodule : mcs_conv_gate

// ==== sim/mcs_conv_model.sv ====
`timescale 1ns/100ps
// Converter stand-in: answers each start after a short or long conversion
module mcs_conv_model
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Requests
	input wire logic conv_start_i,
	input wire logic slow_i,
	// Answers
	output logic conv_done_o,
	output logic [15:0] conv_data_o
);
	logic busy_ff;
	logic [3:0] wait_ff;
	logic [15:0] seed_ff;
	// Data lines toggle outside the done cycle so a stale value never passes
	always_ff @(posedge mclk_i)
	begin
		conv_done_o <= 1'b0;
		conv_data_o <= ~conv_data_o;
		if (!resetn_i)
		begin
			busy_ff <= 1'b0;
			wait_ff <= 4'h0;
			seed_ff <= 16'h1234;
			conv_data_o <= 16'hFFFF;
		end
		else if (busy_ff && wait_ff == 4'h0)
		begin
			conv_done_o <= 1'b1;
			conv_data_o <= seed_ff;
			seed_ff <= seed_ff + 16'h3A7F;
			busy_ff <= 1'b0;
		end
		else if (busy_ff)
			wait_ff <= wait_ff - 4'h1;
		else if (conv_start_i)
		begin
			busy_ff <= 1'b1;
			wait_ff <= slow_i ? 4'h6 : 4'h0;
		end
	end
endmodule : mcs_conv_model

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`include "mcs_cfg.svh"
module testbench
	import mcs_pkg::*;
;
	logic mclk_i, resetn_i, avs_read_i, avs_write_i, slow;
	logic [3:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, r;
	logic avs_waitrequest_o, conv_done_i, conv_start_o, conv_order_o, input_short_o, corr_valid_o;
	logic [15:0] conv_data_i, corr_data_o;
	logic [3:0] conv_res_o;
	logic [5:0] zero_shift_code_o;
	mcs_src_type mux_sel_o;
	mcs_slot_type corr_slot_o;
	logic [19:0] meas_q[$], out_q[$];
	mcs_slot_type exp_q[$];
	int mismatches, cmp_count;
	logic [5:0] sv[4] = '{6'h1F, 6'h21, 6'h14, 6'h20};
	logic [5:0] se[4] = '{6'h1F, 6'h21, 6'h14, 6'h14};

	mcs_sequencer mcs_sequencer_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i), .conv_start_o(conv_start_o), .conv_order_o(conv_order_o),
		.conv_res_o(conv_res_o), .mux_sel_o(mux_sel_o), .input_short_o(input_short_o),
		.zero_shift_code_o(zero_shift_code_o), .corr_data_o(corr_data_o),
		.corr_slot_o(corr_slot_o), .corr_valid_o(corr_valid_o));
	mcs_conv_model mcs_conv_model_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.conv_start_i(conv_start_o), .slow_i(slow), .conv_done_o(conv_done_i),
		.conv_data_o(conv_data_i));

	always #10 mclk_i = ~mclk_i;

	// Front-end state is captured at done, result at the following valid pulse
	always @(posedge mclk_i)
		if (resetn_i === 1'b1)
		begin
			if (conv_done_i === 1'b1)
				meas_q.push_back({mux_sel_o, input_short_o, conv_data_i});
			if (corr_valid_o === 1'b1)
				out_q.push_back({corr_slot_o, corr_data_o});
		end

	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task hang;
		mismatches++;
		wrap_up();
	endtask : hang

	// ----
	// Bus cycles
	// ----
	task av_cycle(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int i;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		for (i = 0; i < 50; i++)
		begin
			@(posedge mclk_i);
			if (avs_waitrequest_o === 1'b0)
				break;
		end
		if (i == 50)
			hang();
		r = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge mclk_i);
	endtask : av_cycle

	function automatic mcs_src_type src_of(input logic [1:0] c);
		return c == 2'h1 ? MCS_SRC_BRRES : c == 2'h2 ? MCS_SRC_THERM : MCS_SRC_DIODE;
	endfunction : src_of

	function automatic mcs_src_type exp_mux(input mcs_slot_type s, input logic [31:0] c);
		case (s)
			MCS_SL_ST_BR: return MCS_SRC_BRIDGE;
			MCS_SL_ST_T1, MCS_SL_T1: return src_of(c[`MCS_T1SRC_HI:`MCS_T1SRC_LO]);
			MCS_SL_T2: return src_of(c[`MCS_T2SRC_HI:`MCS_T2SRC_LO]);
			MCS_SL_CMV: return MCS_SRC_CMV;
			default: return MCS_SRC_ZERO;
		endcase
	endfunction : exp_mux

	task add(input int n, input mcs_slot_type s);
		repeat (n) exp_q.push_back(MCS_SL_ST_BR);
		exp_q.push_back(s);
	endtask : add

	// ----
	// Expected slot stream against what the front end and outputs showed
	// ----
	task run_check(input logic [31:0] c, input logic st, input int loops);
		int n, k;
		logic [19:0] m, o;
		n = 1 << c[`MCS_CNT_HI:`MCS_CNT_LO];
		exp_q.delete();
		if (st)
		begin
			exp_q = '{MCS_SL_ST_BR, MCS_SL_ST_AZ};
			if (c[`MCS_T1E_BIT])
				exp_q = {exp_q, MCS_SL_ST_T1, MCS_SL_ST_T1AZ};
		end
		repeat (loops)
		begin
			add(n, MCS_SL_T1AZ);
			add(n, MCS_SL_T1);
			add(n, MCS_SL_BRAZ);
			if (c[`MCS_T2E_BIT])
			begin
				add(n, MCS_SL_T2AZ);
				add(n, MCS_SL_T2);
			end
			add(n, MCS_SL_CMV);
		end
		foreach (exp_q[i])
		begin
			for (k = 0; k < 200 && out_q.size() == 0; k++)
				@(posedge mclk_i);
			if (k == 200 || meas_q.size() == 0)
				hang();
			m = meas_q.pop_front();
			o = out_q.pop_front();
			cmp(32'(o[19:16]), 32'(exp_q[i]));
			cmp(32'(m[19:17]), 32'(exp_mux(exp_q[i], c)));
			cmp(32'(m[16]), 32'(exp_mux(exp_q[i], c) == MCS_SRC_ZERO));
			cmp(32'(o[15:0]), 32'(m[15:0]));
		end
	endtask : run_check

	task sync_cmv;
		int k;
		for (k = 0; k < 5000; k++)
		begin
			@(posedge mclk_i);
			if (corr_valid_o === 1'b1 && corr_slot_o === MCS_SL_CMV)
				break;
		end
		if (k == 5000)
			hang();
		@(negedge mclk_i);
		meas_q.delete();
		out_q.delete();
	endtask : sync_cmv

	initial
	begin
		mclk_i = 1'b0;
		resetn_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 4'h0;
		avs_writedata_i = 32'h0;
		slow = 1'b0;
		repeat (5) @(posedge mclk_i);
		resetn_i <= 1'b1;
		run_check(`MCS_CYCLE_RST, 1'b1, 2);
		av_cycle(1'b0, `MCS_ADDR_CYCLE, 32'h0);
		cmp(r, `MCS_CYCLE_RST);
		av_cycle(1'b0, 4'h2, 32'h0);
		cmp(r, 32'h0);
		av_cycle(1'b0, `MCS_ADDR_SHIFT, 32'h0);
		cmp(r, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			av_cycle(1'b1, `MCS_ADDR_SHIFT, 32'(sv[i]));
			av_cycle(1'b0, `MCS_ADDR_SHIFT, 32'h0);
			cmp(r, 32'(se[i]));
			cmp(32'(zero_shift_code_o), 32'(se[i]));
		end
		slow <= 1'b1;
		av_cycle(1'b1, `MCS_ADDR_CYCLE, 32'h000D_7880);
		sync_cmv();
		run_check(32'h000D_7880, 1'b0, 2);
		cmp(32'(conv_order_o), 32'h1);
		cmp(32'(conv_res_o), 32'hB);
		slow <= 1'b0;
		av_cycle(1'b1, `MCS_ADDR_CYCLE, 32'h0017_EF80);
		av_cycle(1'b0, `MCS_ADDR_STATUS, 32'h0);
		cmp(32'(r[8]), 32'h1);
		cmp(32'(conv_order_o), 32'h1);
		cmp(32'(conv_res_o), 32'hB);
		sync_cmv();
		run_check(32'h0017_EF80, 1'b0, 1);
		// Second reset, then a start routine without the main temperature channel
		resetn_i <= 1'b0;
		repeat (5) @(posedge mclk_i);
		meas_q.delete();
		out_q.delete();
		cmp(32'(zero_shift_code_o), 32'h0);
		cmp(32'(conv_res_o), 32'h9);
		resetn_i <= 1'b1;
		av_cycle(1'b1, `MCS_ADDR_CYCLE, 32'h0000_3400);
		run_check(32'h0000_3400, 1'b1, 1);
		cmp(32'(conv_order_o), 32'h0);
		wrap_up();
	end
endmodule : testbench
